/* File: core/psm_defines.svh */
// Register offsets, field positions, reset values and timing counts of the power mode sequencer
`ifndef PSM_DEFINES_SVH
`define PSM_DEFINES_SVH

`define PSM_ADDR_W            12
`define PSM_CTRL_OFFSET       12'h000
`define PSM_STATUS_OFFSET     12'h004

`define PSM_CTRL_SLOW_BIT     0
`define PSM_CTRL_DIV_LSB      1
`define PSM_CTRL_DIV_MSB      2
`define PSM_CTRL_OIE_BIT      3
`define PSM_CTRL_SHORT_BIT    4
`define PSM_CTRL_WDGOPT_BIT   5
`define PSM_CTRL_RESET        6'h00

`define PSM_STAT_MODE_LSB     0
`define PSM_STAT_MODE_MSB     2
`define PSM_STAT_SLOW_BIT     3
`define PSM_STAT_LVL_LSB      4
`define PSM_STAT_LVL_MSB      5
`define PSM_STAT_BUSY_BIT     6

`define PSM_LEVEL_ENABLE_ALL  2'h2
`define PSM_LEVEL_RESET       2'h3

`define PSM_WAKE_LONG_CYC     4096
`define PSM_WAKE_SHORT_CYC    256
`define PSM_WAKE_LONG_LOAD    12'(`PSM_WAKE_LONG_CYC - 1)
`define PSM_WAKE_SHORT_LOAD   12'(`PSM_WAKE_SHORT_CYC - 1)

`define PSM_RESP_OKAY         2'h0
`define PSM_RESP_SLVERR       2'h2

`endif

/* File: core/psm_pkg.sv */
// Types shared by the power mode sequencer files
package psm_pkg;

	typedef enum logic [2:0]
	{
		PSM_RUN,
		PSM_WAIT,
		PSM_ACTIVE_HALT,
		PSM_HALT,
		PSM_WAKE
	} psm_mode_e;

	typedef struct packed
	{
		logic       watchdog_halt_option;
		logic       wake_delay_short;
		logic       oscillator_interrupt_enable;
		logic [1:0] cpu_clock_divider_select;
		logic       slow_mode_enable;
	} psm_ctrl_s;

	typedef struct packed
	{
		logic       wait_for_interrupt_instr;
		logic       halt_instr;
	} psm_instr_s;

	typedef struct packed
	{
		logic       irq_pending;
		logic       irq_wake_capable;
		logic       irq_timebase;
		logic [1:0] irq_priority;
	} psm_irq_s;

	typedef struct packed
	{
		logic       ccr_load;
		logic [1:0] ccr_level;
		logic       cc_push;
		logic       irq_service;
	} psm_cpu_s;

	typedef struct packed
	{
		logic       osc_enable;
		logic       timebase_clk_en;
		logic       wdg_freeze;
		logic       wdg_halt_reset;
	} psm_sys_s;

endpackage

/* File: core/psm_clk_div.sv */
// Master clock divider producing gated CPU and peripheral clock enables
`timescale 1ns/1ps
`include "psm_defines.svh"

module psm_clk_div
(
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Divider request
	input  wire logic       slow_mode_enable,
	input  wire logic [1:0] cpu_clock_divider_select,
	// Gates
	input  wire logic       cpu_gate,
	input  wire logic       periph_gate,
	// Enables
	output logic            cpu_tick_r,
	output logic            periph_tick_r
);
	logic [2:0] div_r;
	logic [2:0] div_nxt;
	logic [3:0] cnt_r;
	logic [3:0] limit;
	logic       terminal;

	// Divide by 1 in run, by 2 to 16 in slow mode
	assign div_nxt  = slow_mode_enable ? (3'h1 + {1'b0, cpu_clock_divider_select}) : 3'h0;
	assign limit    = 4'((5'h01 << div_r) - 5'h01);
	assign terminal = (cnt_r == limit);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cnt_r <= 4'h0;
			div_r <= 3'h0;
		end
		else if (terminal)
		begin
			cnt_r <= 4'h0;
			div_r <= div_nxt;
		end
		else
		begin
			cnt_r <= cnt_r + 4'h1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cpu_tick_r    <= 1'b0;
			periph_tick_r <= 1'b0;
		end
		else
		begin
			cpu_tick_r    <= terminal & cpu_gate;
			periph_tick_r <= terminal & periph_gate;
		end
	end
endmodule

/* File: core/psm_top.sv */
// Power mode sequencer: run, slow, wait, active-halt and halt with AXI4-Lite control
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "psm_defines.svh"

module psm_top
(
	// Clock and reset
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	// AXI4-Lite write address
	input  wire logic [`PSM_ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic [2:0]               s_axi_awprot,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [`PSM_ADDR_W-1:0]   s_axi_araddr,
	input  wire logic [2:0]               s_axi_arprot,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	// CPU core instructions and interrupt controller requests
	input  wire psm_pkg::psm_instr_s      instr,
	input  wire psm_pkg::psm_irq_s        irq,
	input  wire logic                     watchdog_active,
	// Clock enables
	output logic                          cpu_clk_en,
	output logic                          periph_clk_en,
	// CPU core and system controls
	output psm_pkg::psm_cpu_s             cpu_ctl_r,
	output psm_pkg::psm_sys_s             sys_ctl_r,
	output psm_pkg::psm_mode_e            mode_r
);
	import psm_pkg::*;
	localparam logic [`PSM_ADDR_W-1:0] ctrl_addr   = `PSM_CTRL_OFFSET;
	localparam logic [`PSM_ADDR_W-1:0] status_addr = `PSM_STATUS_OFFSET;

	psm_ctrl_s  ctrl_r;
	psm_mode_e  mode_nxt;
	logic       from_active_r;
	logic [11:0] wake_cnt_r;
	logic       wake_load;
	logic       wake_done;
	logic       halt_like;
	logic       cpu_gate;
	logic       periph_gate;

	// Write channel holding
	logic [`PSM_ADDR_W-1:0] aw_addr_r;
	logic                   aw_held_r;
	logic [31:0]            w_data_r;
	logic [3:0]             w_strb_r;
	logic                   w_held_r;
	logic                   do_write;
	logic                   wr_ctrl;
	logic [31:0]            status_word;

	// Register bus
	assign do_write = aw_held_r & w_held_r & ~s_axi_bvalid;
	assign wr_ctrl  = do_write & (aw_addr_r[`PSM_ADDR_W-1:2] == ctrl_addr[`PSM_ADDR_W-1:2]);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			aw_held_r     <= 1'b0;
			aw_addr_r     <= '0;
		end
		else if (s_axi_awvalid & s_axi_awready)
		begin
			s_axi_awready <= 1'b0;
			aw_held_r     <= 1'b1;
			aw_addr_r     <= s_axi_awaddr;
		end
		else if (s_axi_bvalid & s_axi_bready)
		begin
			s_axi_awready <= 1'b1;
		end
		else if (do_write)
		begin
			aw_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_wready <= 1'b1;
			w_held_r     <= 1'b0;
			w_data_r     <= 32'h0;
			w_strb_r     <= 4'h0;
		end
		else if (s_axi_wvalid & s_axi_wready)
		begin
			s_axi_wready <= 1'b0;
			w_held_r     <= 1'b1;
			w_data_r     <= s_axi_wdata;
			w_strb_r     <= s_axi_wstrb;
		end
		else if (s_axi_bvalid & s_axi_bready)
		begin
			s_axi_wready <= 1'b1;
		end
		else if (do_write)
		begin
			w_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `PSM_RESP_OKAY;
		end
		else if (do_write)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (wr_ctrl | (aw_addr_r[`PSM_ADDR_W-1:2] == status_addr[`PSM_ADDR_W-1:2]))
				? `PSM_RESP_OKAY : `PSM_RESP_SLVERR;
		end
		else if (s_axi_bready)
		begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Control register, low byte lane only
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_r <= psm_ctrl_s'(`PSM_CTRL_RESET);
		end
		else if (wr_ctrl & w_strb_r[0])
		begin
			ctrl_r <= psm_ctrl_s'(w_data_r[`PSM_CTRL_WDGOPT_BIT:`PSM_CTRL_SLOW_BIT]);
		end
	end

	always_comb
	begin
		status_word = 32'h0;
		status_word[`PSM_STAT_MODE_MSB:`PSM_STAT_MODE_LSB] = mode_r;
		status_word[`PSM_STAT_SLOW_BIT] = ctrl_r.slow_mode_enable;
		status_word[`PSM_STAT_LVL_MSB:`PSM_STAT_LVL_LSB] = cpu_ctl_r.ccr_level;
		status_word[`PSM_STAT_BUSY_BIT] = (mode_r == PSM_WAKE);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= `PSM_RESP_OKAY;
		end
		else if (s_axi_arvalid & s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			unique case (s_axi_araddr[`PSM_ADDR_W-1:2])
				ctrl_addr[`PSM_ADDR_W-1:2]:
				begin
					s_axi_rdata <= {26'h0, ctrl_r};
					s_axi_rresp <= `PSM_RESP_OKAY;
				end
				status_addr[`PSM_ADDR_W-1:2]:
				begin
					s_axi_rdata <= status_word;
					s_axi_rresp <= `PSM_RESP_OKAY;
				end
				default:
				begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= `PSM_RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rvalid & s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Mode sequencing
	assign wake_done = (wake_cnt_r == 12'h000);

	always_comb
	begin
		mode_nxt  = mode_r;
		wake_load = 1'b0;
		unique case (mode_r)
			PSM_RUN:
			begin
				if (instr.halt_instr)
				begin
					mode_nxt = ctrl_r.oscillator_interrupt_enable ? PSM_ACTIVE_HALT : PSM_HALT;
				end
				else if (instr.wait_for_interrupt_instr)
				begin
					mode_nxt = PSM_WAIT;
				end
			end
			PSM_WAIT:
			begin
				if (irq.irq_pending)
				begin
					mode_nxt = PSM_RUN;
				end
			end
			PSM_ACTIVE_HALT:
			begin
				if (irq.irq_timebase | irq.irq_wake_capable)
				begin
					mode_nxt  = PSM_WAKE;
					wake_load = 1'b1;
				end
			end
			PSM_HALT:
			begin
				if (irq.irq_wake_capable)
				begin
					mode_nxt  = PSM_WAKE;
					wake_load = 1'b1;
				end
			end
			PSM_WAKE:
			begin
				if (wake_done)
				begin
					mode_nxt = PSM_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mode_r <= PSM_RUN;
		end
		else
		begin
			mode_r <= mode_nxt;
		end
	end

	// Wake delay counter
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wake_cnt_r    <= 12'h000;
			from_active_r <= 1'b0;
		end
		else if (wake_load)
		begin
			wake_cnt_r    <= ctrl_r.wake_delay_short ? `PSM_WAKE_SHORT_LOAD : `PSM_WAKE_LONG_LOAD;
			from_active_r <= (mode_r == PSM_ACTIVE_HALT);
		end
		else if ((mode_r == PSM_WAKE) & ~wake_done)
		begin
			wake_cnt_r <= wake_cnt_r - 12'h001;
		end
	end

	// Early clear of the enable during an active-halt wake drops to halt behaviour
	assign halt_like   = (mode_r == PSM_HALT) |
		((mode_r == PSM_WAKE) & from_active_r & ~ctrl_r.oscillator_interrupt_enable);
	assign cpu_gate    = (mode_r == PSM_RUN);
	assign periph_gate = (mode_r == PSM_RUN) | (mode_r == PSM_WAIT);

	psm_clk_div u_clk_div
	(
		.aclk                     (aclk),
		.aresetn                  (aresetn),
		.slow_mode_enable         (ctrl_r.slow_mode_enable),
		.cpu_clock_divider_select (ctrl_r.cpu_clock_divider_select),
		.cpu_gate                 (cpu_gate),
		.periph_gate              (periph_gate),
		.cpu_tick_r               (cpu_clk_en),
		.periph_tick_r            (periph_clk_en)
	);

	// CPU core controls: mask forcing on entry, push and priority on service
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cpu_ctl_r.ccr_load    <= 1'b0;
			cpu_ctl_r.ccr_level   <= `PSM_LEVEL_RESET;
			cpu_ctl_r.cc_push     <= 1'b0;
			cpu_ctl_r.irq_service <= 1'b0;
		end
		else
		begin
			cpu_ctl_r.ccr_load    <= 1'b0;
			cpu_ctl_r.cc_push     <= 1'b0;
			cpu_ctl_r.irq_service <= 1'b0;
			if ((mode_r == PSM_RUN) & (mode_nxt != PSM_RUN))
			begin
				cpu_ctl_r.ccr_load  <= 1'b1;
				cpu_ctl_r.ccr_level <= `PSM_LEVEL_ENABLE_ALL;
			end
			else if ((mode_r != PSM_RUN) & (mode_nxt == PSM_RUN))
			begin
				cpu_ctl_r.ccr_load    <= 1'b1;
				cpu_ctl_r.ccr_level   <= irq.irq_priority;
				cpu_ctl_r.cc_push     <= 1'b1;
				cpu_ctl_r.irq_service <= 1'b1;
			end
		end
	end

	// Oscillator, timebase and watchdog controls
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sys_ctl_r.osc_enable      <= 1'b1;
			sys_ctl_r.timebase_clk_en <= 1'b1;
			sys_ctl_r.wdg_freeze      <= 1'b0;
			sys_ctl_r.wdg_halt_reset  <= 1'b0;
		end
		else
		begin
			sys_ctl_r.osc_enable      <= ~halt_like;
			sys_ctl_r.timebase_clk_en <= ~halt_like & ((mode_r == PSM_RUN) | (mode_r == PSM_WAIT) |
				(mode_r == PSM_ACTIVE_HALT) | (mode_r == PSM_WAKE));
			sys_ctl_r.wdg_freeze      <= (mode_r == PSM_ACTIVE_HALT) |
				((mode_r == PSM_WAKE) & from_active_r & ctrl_r.oscillator_interrupt_enable);
			sys_ctl_r.wdg_halt_reset  <= (mode_r == PSM_RUN) & (mode_nxt == PSM_HALT) & watchdog_active &
				~ctrl_r.watchdog_halt_option;
		end
	end
endmodule

/* File: bench/psm_top_asserts.sv */
// Port-level assertions for the power mode sequencer
`timescale 1ns/1ps

module psm_top_asserts
(
	// Clock and reset
	input  wire logic               aclk,
	input  wire logic               aresetn,
	// Observed ports
	input  wire psm_pkg::psm_irq_s  irq,
	input  wire logic               cpu_clk_en,
	input  wire logic               periph_clk_en,
	input  wire psm_pkg::psm_cpu_s  cpu_ctl_r,
	input  wire psm_pkg::psm_sys_s  sys_ctl_r,
	input  wire psm_pkg::psm_mode_e mode_r
);
	import psm_pkg::*;

	int wake_cnt_r;

	// Length of the current wake interval in master clock cycles
	always_ff @(posedge aclk)
	begin
		if (!aresetn || mode_r != PSM_WAKE)
			wake_cnt_r <= 0;
		else
			wake_cnt_r <= wake_cnt_r + 1;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_entered(psm_mode_e m);
		mode_r == m && $past(mode_r) != m;
	endsequence
	sequence s_settled(psm_mode_e m);
		mode_r == m && $past(mode_r) == m;
	endsequence
	sequence s_service;
		mode_r == PSM_RUN && cpu_ctl_r.irq_service && cpu_ctl_r.cc_push && cpu_ctl_r.ccr_load;
	endsequence

	wait_level_a: assert property (s_entered(PSM_WAIT) |-> cpu_ctl_r.ccr_load && cpu_ctl_r.ccr_level == 2'h2)
		else $error("wait entry level wrong");
	ahalt_level_a: assert property (s_entered(PSM_ACTIVE_HALT) |-> cpu_ctl_r.ccr_load && cpu_ctl_r.ccr_level == 2'h2)
		else $error("active halt entry level wrong");
	wait_cpu_a: assert property (s_settled(PSM_WAIT) |-> !cpu_clk_en)
		else $error("cpu ticks in wait");
	ahalt_clk_a: assert property (s_settled(PSM_ACTIVE_HALT) |-> !cpu_clk_en && !periph_clk_en && sys_ctl_r.osc_enable && sys_ctl_r.timebase_clk_en)
		else $error("active halt clocks wrong");
	halt_osc_a: assert property (s_settled(PSM_HALT) |-> !sys_ctl_r.osc_enable && !periph_clk_en && !cpu_clk_en)
		else $error("halt clocks running");
	wdg_freeze_a: assert property (s_settled(PSM_ACTIVE_HALT) |-> sys_ctl_r.wdg_freeze && !sys_ctl_r.wdg_halt_reset)
		else $error("watchdog not frozen");
	wait_exit_a: assert property (mode_r == PSM_WAIT && irq.irq_pending |=> s_service)
		else $error("wait exit wrong");
	svc_level_a: assert property (cpu_ctl_r.irq_service |-> s_service ##0 cpu_ctl_r.ccr_level == $past(irq.irq_priority))
		else $error("service level wrong");
	wake_len_a: assert property ($past(mode_r) == PSM_WAKE && mode_r != PSM_WAKE |-> (wake_cnt_r == 256 || wake_cnt_r == 4096) ##0 s_service)
		else $error("wake length wrong");
	wake_gate_a: assert property (s_settled(PSM_WAKE) |-> !cpu_clk_en)
		else $error("cpu ticks in wake");
endmodule

/* File: bench/psm_core_model.sv */
// Behavioural interrupt controller and core beside the sequencer
`timescale 1ns/1ps

module psm_core_model
(
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// Bench requests: 0 pending, 1 wake capable, 2 timebase
	input  wire logic [2:0]        req,
	input  wire logic [1:0]        prio,
	// Sequencer side
	input  wire psm_pkg::psm_cpu_s cpu_ctl_r,
	output psm_pkg::psm_irq_s      irq
);
	import psm_pkg::*;

	initial irq = '0;

	// Requests stay pending until the core fetches the vector
	always @(posedge aclk)
	begin
		if (!aresetn || cpu_ctl_r.irq_service)
			irq <= '0;
		else
		begin
			irq.irq_pending <= irq.irq_pending | (|req);
			irq.irq_wake_capable <= irq.irq_wake_capable | req[1];
			irq.irq_timebase <= irq.irq_timebase | req[2];
			irq.irq_priority <= prio;
		end
	end
endmodule

/* File: bench/psm_top_tb_top.sv */
// Testbench for the power mode sequencer
`timescale 1ns/1ps
`include "psm_defines.svh"
`define CHK(nm, e, v) begin num_checks++; if ((v) !== (e)) begin miscompares++; \
	$display("wrong value %s exp %0h got %0h", nm, e, v); end end

module psm_top_tb_top;
	import psm_pkg::*;

	logic        aclk = 1'h0;
	logic        aresetn = 1'h0;
	logic [11:0] s_axi_awaddr = 12'h0;
	logic [11:0] s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [31:0] s_axi_rdata;
	logic        s_axi_awvalid = 1'h0;
	logic        s_axi_wvalid = 1'h0;
	logic        s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0;
	logic        s_axi_rready = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	psm_instr_s  instr = '0;
	psm_irq_s    irq;
	psm_cpu_s    cpu_ctl_r;
	psm_sys_s    sys_ctl_r;
	psm_mode_e   mode_r;
	logic        watchdog_active = 1'h0;
	logic        cpu_clk_en, periph_clk_en;
	logic [2:0]  req = 3'h0;
	logic [31:0] rd;
	int          miscompares = 0;
	int          num_checks = 0;
	int          nc, np;

	always #12.5 aclk = ~aclk;

	psm_top psm_top_i (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .instr(instr), .irq(irq), .watchdog_active(watchdog_active),
		.cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .cpu_ctl_r(cpu_ctl_r),
		.sys_ctl_r(sys_ctl_r), .mode_r(mode_r));

	psm_core_model psm_core_model_i (.aclk(aclk), .aresetn(aresetn), .req(req), .prio(2'h1),
		.cpu_ctl_r(cpu_ctl_r), .irq(irq));

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Ready and valid are sampled mid-cycle, so the next rising edge is the handshake edge
	task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		logic ha, hw, hb;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (n = 0; n < 50; n++)
		begin
			@(negedge aclk);
			ha = s_axi_awvalid && s_axi_awready;
			hw = s_axi_wvalid && s_axi_wready;
			hb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ha)
				s_axi_awvalid <= 1'h0;
			if (hw)
				s_axi_wvalid <= 1'h0;
			if (hb)
				break;
		end
		s_axi_bready <= 1'h0;
		if (n == 50)
		begin
			miscompares++;
			tally_and_finish();
		end
	endtask

	task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		logic hr, hv;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (n = 0; n < 50; n++)
		begin
			@(negedge aclk);
			hr = s_axi_arvalid && s_axi_arready;
			hv = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (hr)
				s_axi_arvalid <= 1'h0;
			if (hv)
				break;
		end
		s_axi_rready <= 1'h0;
		if (n == 50)
		begin
			miscompares++;
			tally_and_finish();
		end
	endtask

	task automatic wait_mode(input psm_mode_e m, input int lim);
		int n;
		for (n = 0; n < lim; n++)
		begin
			@(negedge aclk);
			if (mode_r === m)
				break;
		end
		if (n == lim)
		begin
			miscompares++;
			tally_and_finish();
		end
	endtask

	task automatic count(input int cyc);
		nc = 0;
		np = 0;
		repeat (cyc)
		begin
			@(negedge aclk);
			nc += (cpu_clk_en === 1'h1);
			np += (periph_clk_en === 1'h1);
		end
	endtask

	task automatic pulse(input logic h);
		@(posedge aclk);
		instr <= {~h, h};
		@(posedge aclk);
		instr <= '0;
	endtask

	task automatic poke(input logic [2:0] k);
		@(posedge aclk);
		req <= k;
		@(posedge aclk);
		req <= 3'h0;
	endtask

	task automatic wake_len(input int exp_n);
		int n;
		for (n = 0; n < 5000 && mode_r !== PSM_RUN; n++)
			@(negedge aclk);
		`CHK("wake cycles", exp_n, n)
		if (n == 5000)
			tally_and_finish();
	endtask

	initial
	begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		axr(`PSM_STATUS_OFFSET, rd, rsp);
		`CHK("status", 32'h30, rd)
		axr(`PSM_CTRL_OFFSET, rd, rsp);
		`CHK("ctrl", 32'h0, rd)
		axr(12'h100, rd, rsp);
		`CHK("read resp", `PSM_RESP_SLVERR, rsp)
		axw(12'h100, 32'h1, rsp);
		`CHK("write resp", `PSM_RESP_SLVERR, rsp)
		count(32);
		`CHK("run ticks", 32, nc)
		$display("test reset done");
		for (int s = 0; s < 4; s++)
		begin
			axw(`PSM_CTRL_OFFSET, 32'(1 + 2 * s), rsp);
			count(40);
			count(64);
			`CHK("slow ticks", 64 >> (s + 1), nc)
		end
		$display("test slow done");
		pulse(1'h0);
		wait_mode(PSM_WAIT, 20);
		`CHK("wait level", 2'h2, cpu_ctl_r.ccr_level)
		count(64);
		`CHK("wait cpu ticks", 0, nc)
		`CHK("wait periph ticks", 4, np)
		axr(`PSM_STATUS_OFFSET, rd, rsp);
		`CHK("wait status", 32'h29, rd)
		poke(3'h1);
		wait_mode(PSM_RUN, 10);
		`CHK("service level", 2'h1, cpu_ctl_r.ccr_level)
		$display("test wait done");
		axw(`PSM_CTRL_OFFSET, 32'h18, rsp);
		@(posedge aclk);
		watchdog_active <= 1'h1;
		pulse(1'h1);
		wait_mode(PSM_ACTIVE_HALT, 20);
		`CHK("active halt watchdog reset", 1'h0, sys_ctl_r.wdg_halt_reset)
		poke(3'h1);
		count(20);
		`CHK("active halt hold", PSM_ACTIVE_HALT, mode_r)
		`CHK("active halt ticks", 0, nc + np)
		`CHK("watchdog freeze", 1'h1, sys_ctl_r.wdg_freeze)
		poke(3'h4);
		wait_mode(PSM_WAKE, 10);
		wake_len(`PSM_WAKE_SHORT_CYC);
		$display("test active halt done");
		axw(`PSM_CTRL_OFFSET, 32'h0, rsp);
		pulse(1'h1);
		wait_mode(PSM_HALT, 20);
		`CHK("halt watchdog reset", 1'h1, sys_ctl_r.wdg_halt_reset)
		poke(3'h4);
		count(8);
		`CHK("halt hold", PSM_HALT, mode_r)
		`CHK("halt osc", 1'h0, sys_ctl_r.osc_enable)
		poke(3'h2);
		wait_mode(PSM_WAKE, 10);
		@(negedge aclk);
		`CHK("wake osc", 1'h1, sys_ctl_r.osc_enable)
		// One wake cycle was spent on the oscillator check above
		wake_len(`PSM_WAKE_LONG_CYC - 1);
		$display("test halt done");
		tally_and_finish();
	end
endmodule

bind psm_top psm_top_asserts psm_top_asserts_i (.aclk(aclk), .aresetn(aresetn), .irq(irq),
	.cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .cpu_ctl_r(cpu_ctl_r),
	.sys_ctl_r(sys_ctl_r), .mode_r(mode_r));
